// File: core/frcd_decoder.v
// Instruction capture and decode for the flash register command set
`timescale 1ns/10ps
`include "frcd_consts.vh"

// Notes on behaviour
// (RL1) 9F identification, AF quad identification, quad ok
// (RL2) 5A parameters: three address bytes, 50 MHz
// (RL3) 05 status one, any mode, 133 MHz
// (RL4) 07 status two, refused in quad mode
// (RL5) 35 config one, refused in quad mode
// (RL6) 01, 06, 04 register writes, quad ok
// (RL7) 30 clears fail flags, quad ok
// (RL8) Config bit turns 30 into resume
// (RL9) 82 also clears fail flags
// (RL10) B7 enters wide address, refused quad
// (RL11) 41 reads learning pattern, refused quad
// (RL12) 43 programs nonvolatile learning register, refused quad
// (RL13) 4A writes volatile learning register, refused quad
// (RL14) Address bytes four when length bit set; the code applies it to 65 and 71 only, 5A stays three
// (RL15) Host avoids refused commands in quad mode
// (RL16) MSB first; quad LSB on line zero
// (RL17) 65 and 71 any register, wide address
// (RL18) Unknown opcode: nop until deselect
module frcd_decoder (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Link pins from the host
  input wire cs_n,
  input wire sck,
  input wire [3:0] io_in,
  // Mode and configuration levels
  input wire all_quad_mode,
  input wire wide_addr_bit,
  input wire clear_fail_disable,
  // Decode results
  output reg cmd_valid_reg,
  output reg [7:0] opcode_reg,
  output reg [4:0] function_reg,
  output reg [2:0] addr_bytes_reg,
  output reg [7:0] max_mhz_reg,
  output reg quad_ok_reg,
  output reg refused_reg
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  wire [`FRCD_PIN_WIDTH-1:0] pins_sync;
  frcd_sync #(.WIDTH(`FRCD_PIN_WIDTH)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({cs_n, sck, io_in}),
    .sync_out(pins_sync)
  );

  wire cs_n_s = pins_sync[`FRCD_PIN_CS];
  wire sck_s = pins_sync[`FRCD_PIN_SCK];
  wire [3:0] io_s = pins_sync[`FRCD_PIN_IO_HI:`FRCD_PIN_IO_LO];

  reg sck_prev_reg;
  wire sck_rise = sck_s & ~sck_prev_reg;

  // ------------------------------------------------------------
  // Decode function: opcode to function, address and quad flag
  // ------------------------------------------------------------
  // Returns {function, addr_bytes, max_mhz, quad_ok}
  function [16:0] frcd_lookup;
    input [7:0] op;
    input wide;
    input clr_off;
    reg [2:0] flex;
    begin
      flex = wide ? `FRCD_ADDR_FOUR : `FRCD_ADDR_THREE; // RL14
      case (op)
        `FRCD_OP_READ_ID: frcd_lookup = {`FRCD_FN_READ_ID, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL1
        `FRCD_OP_READ_QID: frcd_lookup = {`FRCD_FN_READ_QID, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL1
        `FRCD_OP_READ_PARAMS: frcd_lookup = {`FRCD_FN_READ_PARAMS, `FRCD_ADDR_THREE, `FRCD_MHZ_PARAMS, 1'b1}; // RL2
        `FRCD_OP_READ_STAT1: frcd_lookup = {`FRCD_FN_READ_STAT1, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL3
        `FRCD_OP_READ_STAT2: frcd_lookup = {`FRCD_FN_READ_STAT2, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b0}; // RL4
        `FRCD_OP_READ_CFG1: frcd_lookup = {`FRCD_FN_READ_CFG1, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b0}; // RL5
        `FRCD_OP_WRITE_STATCFG: frcd_lookup = {`FRCD_FN_WRITE_STATCFG, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL6
        `FRCD_OP_WRITE_ENABLE_CMD: frcd_lookup = {`FRCD_FN_WRITE_ENABLE_CMD, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL6
        `FRCD_OP_WRDIS: frcd_lookup = {`FRCD_FN_WRDIS, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL6
        `FRCD_OP_CLEAR_FAIL: begin
          // Same opcode doubles as resume when the clear is switched off
          if (clr_off)
            frcd_lookup = {`FRCD_FN_RESUME, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL8
          else
            frcd_lookup = {`FRCD_FN_CLEAR_FAIL, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL7
        end
        `FRCD_OP_CLEAR_FAIL_ALT: frcd_lookup = {`FRCD_FN_CLEAR_FAIL, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL9
        `FRCD_OP_WIDE_ADDR: frcd_lookup = {`FRCD_FN_WIDE_ADDR, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b0}; // RL10
        `FRCD_OP_READ_LEARN: frcd_lookup = {`FRCD_FN_READ_LEARN, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b0}; // RL11
        `FRCD_OP_PROG_NV_LEARN: frcd_lookup = {`FRCD_FN_PROG_NV_LEARN, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b0}; // RL12
        `FRCD_OP_WRITE_V_LEARN: frcd_lookup = {`FRCD_FN_WRITE_V_LEARN, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b0}; // RL13
        `FRCD_OP_READ_ANY: frcd_lookup = {`FRCD_FN_READ_ANY, flex, `FRCD_MHZ_DEFAULT, 1'b1}; // RL17
        `FRCD_OP_WRITE_ANY: frcd_lookup = {`FRCD_FN_WRITE_ANY, flex, `FRCD_MHZ_DEFAULT, 1'b1}; // RL17
        default: frcd_lookup = {`FRCD_FN_NOP, `FRCD_ADDR_NONE, `FRCD_MHZ_DEFAULT, 1'b1}; // RL18
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Instruction shifter
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] shift_reg;
  reg [7:0] shift_next;
  reg [3:0] count_reg;
  reg [3:0] count_next;
  reg quad_latch_reg;
  reg quad_latch_next;
  reg byte_done;
  reg armed_reg;

  // Byte image after one more group; a quad group keeps its LSB on line zero
  wire [7:0] shift_join = quad_latch_reg ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]}; // RL16
  // First group of a frame, shifted into a cleared byte
  wire [7:0] shift_first = all_quad_mode ? {4'h0, io_s} : {7'h00, io_s[0]}; // RL16
  wire [3:0] count_last = quad_latch_reg ? {1'b0, `FRCD_LAST_NIBBLE} : {1'b0, `FRCD_LAST_BIT};
  wire [16:0] look = frcd_lookup(shift_join, wide_addr_bit, clear_fail_disable);

  // ------------------------------------------------------------
  // Link clock edge and frame arming
  // ------------------------------------------------------------
  // Detector resets to the idle low level of the link clock, so no edge follows reset
  always @(posedge clk_sys) begin
    if (rst) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
    end
  end

  // Reset can land inside a host frame; waiting for a deselect keeps a cut byte from decoding
  always @(posedge clk_sys) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (cs_n_s) begin
      armed_reg <= 1'b1;
    end
  end

  // Next frame state: collect one instruction, then ignore the rest of the frame
  always @* begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    quad_latch_next = quad_latch_reg;
    byte_done = 1'b0;
    if (cs_n_s || !armed_reg) begin
      state_next = ST_IDLE;
      count_next = 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Mode is frozen at frame start so a change mid-frame cannot split a byte
          quad_latch_next = all_quad_mode;
          shift_next = 8'h00;
          count_next = 4'h0;
          state_next = ST_SHIFT;
          if (sck_rise) begin
            shift_next = shift_first;
            count_next = 4'h1;
          end
        end
        ST_SHIFT: begin
          if (sck_rise) begin
            shift_next = shift_join;
            count_next = count_reg + 4'h1;
            if (count_reg == count_last) begin
              state_next = ST_DONE;
              byte_done = 1'b1;
            end
          end
        end
        // Bits after the instruction are ignored until deselect
        ST_DONE: state_next = ST_DONE; // RL18
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // Shifter registers
  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      count_reg <= 4'h0;
      quad_latch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      quad_latch_reg <= quad_latch_next;
    end
  end

  // ------------------------------------------------------------
  // Decode results
  // ------------------------------------------------------------
  // Fields hold until the next decode; only the strobe drops after one cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      cmd_valid_reg <= 1'b0;
      opcode_reg <= 8'h00;
      function_reg <= `FRCD_FN_NOP;
      addr_bytes_reg <= `FRCD_ADDR_NONE;
      max_mhz_reg <= 8'h00;
      quad_ok_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= byte_done;
      if (byte_done) begin
        opcode_reg <= shift_join;
        function_reg <= look[`FRCD_LK_FN_HI:`FRCD_LK_FN_LO];
        addr_bytes_reg <= look[`FRCD_LK_ADDR_HI:`FRCD_LK_ADDR_LO];
        max_mhz_reg <= look[`FRCD_LK_MHZ_HI:`FRCD_LK_MHZ_LO];
        quad_ok_reg <= look[`FRCD_LK_QUAD];
        // The host must not send these in quad mode; the flag makes a slip visible
        refused_reg <= quad_latch_reg & ~look[`FRCD_LK_QUAD]; // RL15
      end
    end
  end

endmodule

// File: core/frcd_consts.vh
// Constants for the flash register command decoder
`ifndef FRCD_CONSTS_VH
`define FRCD_CONSTS_VH

// Opcodes
`define FRCD_OP_READ_ID 8'h9F
`define FRCD_OP_READ_QID 8'hAF
`define FRCD_OP_READ_PARAMS 8'h5A
`define FRCD_OP_READ_STAT1 8'h05
`define FRCD_OP_READ_STAT2 8'h07
`define FRCD_OP_READ_CFG1 8'h35
`define FRCD_OP_WRITE_STATCFG 8'h01
`define FRCD_OP_WRITE_ENABLE_CMD 8'h06
`define FRCD_OP_WRDIS 8'h04
`define FRCD_OP_CLEAR_FAIL 8'h30
`define FRCD_OP_CLEAR_FAIL_ALT 8'h82
`define FRCD_OP_WIDE_ADDR 8'hB7
`define FRCD_OP_READ_LEARN 8'h41
`define FRCD_OP_PROG_NV_LEARN 8'h43
`define FRCD_OP_WRITE_V_LEARN 8'h4A
`define FRCD_OP_READ_ANY 8'h65
`define FRCD_OP_WRITE_ANY 8'h71

// Function codes
`define FRCD_FN_NOP 5'h00
`define FRCD_FN_READ_ID 5'h01
`define FRCD_FN_READ_QID 5'h02
`define FRCD_FN_READ_PARAMS 5'h03
`define FRCD_FN_READ_STAT1 5'h04
`define FRCD_FN_READ_STAT2 5'h05
`define FRCD_FN_READ_CFG1 5'h06
`define FRCD_FN_WRITE_STATCFG 5'h07
`define FRCD_FN_WRITE_ENABLE_CMD 5'h08
`define FRCD_FN_WRDIS 5'h09
`define FRCD_FN_CLEAR_FAIL 5'h0A
`define FRCD_FN_RESUME 5'h0B
`define FRCD_FN_WIDE_ADDR 5'h0C
`define FRCD_FN_READ_LEARN 5'h0D
`define FRCD_FN_PROG_NV_LEARN 5'h0E
`define FRCD_FN_WRITE_V_LEARN 5'h0F
`define FRCD_FN_READ_ANY 5'h10
`define FRCD_FN_WRITE_ANY 5'h11

// Clock limits in MHz
`define FRCD_MHZ_PARAMS 8'h32
`define FRCD_MHZ_DEFAULT 8'h85

// Address byte counts
`define FRCD_ADDR_NONE 3'h0
`define FRCD_ADDR_THREE 3'h3
`define FRCD_ADDR_FOUR 3'h4

// Field widths and lane counts
`define FRCD_BITS_PER_BYTE 4'h8
`define FRCD_QUAD_NIBBLES 4'h2
`define FRCD_LAST_BIT 3'h7
`define FRCD_LAST_NIBBLE 3'h1

// Lookup word layout: {function, address bytes, clock limit, quad ok}
`define FRCD_LK_FN_HI 16
`define FRCD_LK_FN_LO 12
`define FRCD_LK_ADDR_HI 11
`define FRCD_LK_ADDR_LO 9
`define FRCD_LK_MHZ_HI 8
`define FRCD_LK_MHZ_LO 1
`define FRCD_LK_QUAD 0

// Synchronised pin bank layout
`define FRCD_PIN_WIDTH 6
`define FRCD_PIN_CS 5
`define FRCD_PIN_SCK 4
`define FRCD_PIN_IO_HI 3
`define FRCD_PIN_IO_LO 0

`endif

// File: core/frcd_sync.v
// Two-flop synchroniser bank for link pins
`timescale 1ns/10ps

module frcd_sync #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Raw and synchronised levels
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second
  always @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

// File: bench/frcd_host_model.sv
// Host link model that sends one instruction per chip-select frame, or the same one twice when tail is set
`timescale 1ns/10ps
module frcd_host_model (
  // Link pins
  input wire logic clk_sys,
  output logic cs_n = 1'h1,
  output logic sck = 1'h0,
  output logic [3:0] io_in = 4'h5
);
  // Four clk_sys low then four high: a 5 MHz link, far under every clock limit
  // A set tail clocks the instruction a second time in the same frame
  task automatic send(input logic [7:0] op, input logic quad, input logic tail);
    @(negedge clk_sys) cs_n = 1'h0;
    repeat (tail ? (quad ? 4 : 16) : (quad ? 2 : 8)) begin
      io_in = quad ? op[7:4] : {~io_in[3:1], op[7]};
      op = quad ? {op[3:0], op[7:4]} : {op[6:0], op[7]};
      repeat (4) @(negedge clk_sys);
      sck = 1'h1;
      repeat (4) @(negedge clk_sys);
      sck = 1'h0;
    end
    cs_n = 1'h1;
    io_in = ~io_in; // Released lines must not keep showing the last bit
    repeat (4) @(negedge clk_sys);
  endtask
endmodule

// File: bench/frcd_decoder_asserts.sv
// Port assertions for the command decoder
`timescale 1ns/10ps
`include "frcd_consts.vh"
module frcd_decoder_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration levels
  input wire logic wide_addr_bit,
  input wire logic clear_fail_disable,
  // Decode results
  input wire logic cmd_valid_reg,
  input wire logic quad_ok_reg,
  input wire logic refused_reg,
  input wire logic [7:0] opcode_reg,
  input wire logic [7:0] max_mhz_reg,
  input wire logic [4:0] function_reg,
  input wire logic [2:0] addr_bytes_reg
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_ident; cmd_valid_reg && opcode_reg == 8'h9F |-> function_reg == `FRCD_FN_READ_ID && quad_ok_reg; endproperty
  a_ident: assert property (p_ident) else $error("identification decode wrong");
  property p_params;
    cmd_valid_reg && opcode_reg == 8'h5A |-> addr_bytes_reg == 3'h3 && max_mhz_reg == 8'h32;
  endproperty
  a_params: assert property (p_params) else $error("parameter read decode wrong");
  property p_stat; cmd_valid_reg && opcode_reg == 8'h05 |-> quad_ok_reg && max_mhz_reg == 8'h85; endproperty
  a_stat: assert property (p_stat) else $error("status one decode wrong");
  property p_noquad;
    cmd_valid_reg && opcode_reg inside {8'h07, 8'h35, 8'hB7, 8'h41, 8'h43, 8'h4A} |-> !quad_ok_reg;
  endproperty
  a_noquad: assert property (p_noquad) else $error("single-lane command allowed in quad");
  property p_write; cmd_valid_reg && opcode_reg inside {8'h01, 8'h04, 8'h06, 8'h82} |-> quad_ok_reg; endproperty
  a_write: assert property (p_write) else $error("write command refused in quad");
  // Opcode 30 changes meaning with the configuration level
  property p_clear;
    cmd_valid_reg && opcode_reg == 8'h30 |-> function_reg == (clear_fail_disable ? `FRCD_FN_RESUME : `FRCD_FN_CLEAR_FAIL);
  endproperty
  a_clear: assert property (p_clear) else $error("clear or resume decode wrong");
  property p_wide;
    cmd_valid_reg && opcode_reg inside {8'h65, 8'h71} |-> addr_bytes_reg == (wide_addr_bit ? 3'h4 : 3'h3);
  endproperty
  a_wide: assert property (p_wide) else $error("address length wrong");
  property p_unknown; cmd_valid_reg && function_reg == `FRCD_FN_NOP |-> quad_ok_reg && !refused_reg; endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode not a no-op");
  // One instruction per frame gives a strobe of exactly one cycle
  sequence s_strobe; cmd_valid_reg; endsequence
  sequence s_quiet; !cmd_valid_reg; endsequence
  property p_pulse; s_strobe |=> s_quiet; endproperty
  a_pulse: assert property (p_pulse) else $error("decode strobe longer than one cycle");
endmodule
bind frcd_decoder frcd_decoder_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .wide_addr_bit(wide_addr_bit),
  .clear_fail_disable(clear_fail_disable), .cmd_valid_reg(cmd_valid_reg), .quad_ok_reg(quad_ok_reg),
  .refused_reg(refused_reg), .opcode_reg(opcode_reg), .max_mhz_reg(max_mhz_reg), .function_reg(function_reg),
  .addr_bytes_reg(addr_bytes_reg));

// File: bench/tb.sv
// Self-checking bench for the command decoder
`timescale 1ns/10ps
`include "frcd_consts.vh"
module tb;
  logic clk_sys = 1'h0, rst = 1'h1, all_quad_mode = 1'h0, wide_addr_bit = 1'h0, clear_fail_disable = 1'h0;
  logic cs_n, sck, cmd_valid_reg, quad_ok_reg, refused_reg;
  logic [3:0] io_in;
  logic [7:0] opcode_reg, max_mhz_reg;
  logic [4:0] function_reg;
  logic [2:0] addr_bytes_reg;
  int miscompares = 0, check_count = 0, cycles = 0;
  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;
  frcd_host_model host_u (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .io_in(io_in));
  frcd_decoder dut_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .all_quad_mode(all_quad_mode), .wide_addr_bit(wide_addr_bit), .clear_fail_disable(clear_fail_disable),
    .cmd_valid_reg(cmd_valid_reg), .opcode_reg(opcode_reg), .function_reg(function_reg),
    .addr_bytes_reg(addr_bytes_reg), .max_mhz_reg(max_mhz_reg), .quad_ok_reg(quad_ok_reg), .refused_reg(refused_reg));
  task automatic close_out;
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, e);
    check_count++;
    miscompares += (g !== e);
    if (g !== e)
      $display("[FAIL] %0t got %h want %h", $time, g, e);
  endtask
  // One frame in mode {quad, wide, clear off}; a refused decode leaves the other fields open
  task automatic go(input logic [7:0] op, input logic [2:0] m, input logic [4:0] fn, input logic [2:0] ab,
    input logic [1:0] okrf);
    logic [5:0] seen = 6'h0;
    @(negedge clk_sys) {all_quad_mode, wide_addr_bit, clear_fail_disable} = m;
    fork
      host_u.send(op, m[2], 1'h0);
      repeat (80) @(negedge clk_sys) seen += (cmd_valid_reg === 1'h1);
    join
    cmp({seen, quad_ok_reg, refused_reg, opcode_reg}, {6'h01, okrf, op});
    if (!okrf[0])
      cmp({fn ? max_mhz_reg : 8'h0, function_reg, addr_bytes_reg},
        {fn ? (op == 8'h5A ? `FRCD_MHZ_PARAMS : `FRCD_MHZ_DEFAULT) : 8'h0, fn, ab});
  endtask
  // Reset mid-frame clears every result, and the rest of the cut frame decodes nothing
  task automatic t_reset;
    logic [5:0] seen = 6'h0;
    fork
      host_u.send(8'h9F, 1'h0, 1'h0);
      begin
        repeat (30) @(negedge clk_sys);
        rst = 1'h1;
        repeat (5) @(negedge clk_sys);
        rst = 1'h0;
        repeat (45) @(negedge clk_sys) seen += (cmd_valid_reg === 1'h1);
      end
    join
    cmp({seen, quad_ok_reg, refused_reg, opcode_reg}, 16'h0000);
    cmp({max_mhz_reg, function_reg, addr_bytes_reg}, 16'h0000);
  endtask
  // Bits after a decoded instruction raise no second strobe, in either lane width
  task automatic t_tail;
    logic [5:0] seen;
    for (int q = 0; q < 2; q++) begin
      seen = 6'h0;
      @(negedge clk_sys) all_quad_mode = q[0];
      fork
        host_u.send(8'h06, q[0], 1'h1);
        repeat (150) @(negedge clk_sys) seen += (cmd_valid_reg === 1'h1);
      join
      cmp({seen, quad_ok_reg, refused_reg, opcode_reg}, {6'h01, 2'h2, 8'h06});
    end
  endtask
  task automatic t_quad_ok;
    logic [7:0] op[8] = '{8'h9F, 8'hAF, 8'h05, 8'h01, 8'h06, 8'h04, 8'h30, 8'h82};
    logic [4:0] fn[8] = '{`FRCD_FN_READ_ID, `FRCD_FN_READ_QID, `FRCD_FN_READ_STAT1, `FRCD_FN_WRITE_STATCFG,
      `FRCD_FN_WRITE_ENABLE_CMD, `FRCD_FN_WRDIS, `FRCD_FN_CLEAR_FAIL, `FRCD_FN_CLEAR_FAIL};
    foreach (op[i])
      go(op[i], 3'h4, fn[i], 3'h0, 2'h2);
  endtask
  task automatic t_noquad;
    logic [7:0] op[6] = '{8'h07, 8'h35, 8'hB7, 8'h41, 8'h43, 8'h4A};
    logic [4:0] fn[6] = '{`FRCD_FN_READ_STAT2, `FRCD_FN_READ_CFG1, `FRCD_FN_WIDE_ADDR, `FRCD_FN_READ_LEARN,
      `FRCD_FN_PROG_NV_LEARN, `FRCD_FN_WRITE_V_LEARN};
    foreach (op[i]) begin
      go(op[i], 3'h0, fn[i], 3'h0, 2'h0);
      go(op[i], 3'h4, fn[i], 3'h0, 2'h1);
    end
  endtask
  task automatic t_addr;
    go(8'h5A, 3'h6, `FRCD_FN_READ_PARAMS, 3'h3, 2'h2);
    go(8'h65, 3'h0, `FRCD_FN_READ_ANY, 3'h3, 2'h2);
    go(8'h71, 3'h2, `FRCD_FN_WRITE_ANY, 3'h4, 2'h2);
    go(8'h65, 3'h6, `FRCD_FN_READ_ANY, 3'h4, 2'h2);
    go(8'h30, 3'h1, `FRCD_FN_RESUME, 3'h0, 2'h2);
    go(8'h03, 3'h4, `FRCD_FN_NOP, 3'h0, 2'h2);
  endtask
  // Cut a hang short well past the roughly 2500 cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end
  // Reset for five cycles, let the pin synchronisers settle, then run
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'h0;
    repeat (3) @(negedge clk_sys);
    t_quad_ok();
    t_reset();
    t_noquad();
    t_addr();
    t_tail();
    close_out();
  end
endmodule
